// ### pfia_regs.svh
`ifndef PFIA_REGS_SVH
`define PFIA_REGS_SVH

// ----------------------------------------
// Register indexes (byte address = 4 x index)
// ----------------------------------------
`define PFIA_IDX_INDIRECT 6'h00
`define PFIA_IDX_CNT_LOW 6'h02
`define PFIA_IDX_FLAGS 6'h03
`define PFIA_IDX_POINTER 6'h04
`define PFIA_IDX_RAM_LO 6'h07
`define PFIA_IDX_BANKED_LO 6'h10
`define PFIA_IDX_WORK 6'h20
`define PFIA_IDX_COUNTER 6'h21
`define PFIA_IDX_STACK1 6'h22
`define PFIA_IDX_STACK2 6'h23
`define PFIA_IDX_HOLE_A 6'h01
`define PFIA_IDX_HOLE_B 6'h05
`define PFIA_IDX_HOLE_C 6'h06

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define PFIA_FLAGS_PAGE_BIT 5
`define PFIA_FLAGS_RESET 8'h18
`define PFIA_FLAGS_WMASK 8'he7
`define PFIA_POINTER_RESET 6'h00
`define PFIA_CNT_MASK_LARGE 10'h3ff
`define PFIA_CNT_MASK_SMALL 10'h1ff

`endif

// ### pfia_pkg.sv
package pfia_pkg;

   // ----------------------------------------
   // Instruction flow kinds
   // ----------------------------------------
   typedef enum logic [2:0] {
      PFIA_OP_STEP = 3'b000,
      PFIA_OP_JUMP = 3'b001,
      PFIA_OP_CALL = 3'b010,
      PFIA_OP_RETLIT = 3'b011,
      PFIA_OP_LOWRES = 3'b100
   } pfia_op_t;

   typedef logic [11:0] pfia_stack_t;

endpackage : pfia_pkg

// ### pfia_core.sv
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`include "pfia_regs.svh"

module pfia_core #(
   parameter bit BANKED = 1'b1
) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic clkEn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic instStep,
   input wire pfia_pkg::pfia_op_t instOp,
   input wire logic [8:0] instTarget,
   input wire logic [7:0] instLit,
   output logic [9:0] cntOut,
   output logic [7:0] workReg,
   output logic instDone
);

   // ----------------------------------------
   // Constants
   // ----------------------------------------
   localparam logic [9:0] CNT_MASK = BANKED ? `PFIA_CNT_MASK_LARGE : `PFIA_CNT_MASK_SMALL;

   // ----------------------------------------
   // State
   // ----------------------------------------
   logic [9:0] cnt_r;
   logic [9:0] cnt_nxt;
   pfia_pkg::pfia_stack_t stk1_r;
   pfia_pkg::pfia_stack_t stk2_r;
   logic [7:0] work_r;
   logic [7:0] flags_r;
   logic [5:0] ptr_r;
   logic [7:0] ram_r [0:63];
   logic pready_r;
   logic pslverr_r;
   logic [31:0] prdata_r;
   logic done_r;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [5:0] ramIndex(input logic [4:0] addr, input logic bank);
      logic upper;
      upper = (addr >= `PFIA_IDX_BANKED_LO);
      ramIndex = {bank & upper, addr};
   endfunction : ramIndex

   function automatic logic [9:0] lowLoad(input logic [9:0] base, input logic [7:0] lowByte);
      lowLoad = (base | {2'b00, lowByte}) & CNT_MASK;
   endfunction : lowLoad

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   wire apbAccess = psel & penable;
   // Transfer completes on the ready cycle
   wire apbFire = apbAccess & pready_r;
   wire [5:0] regIdx = paddr[7:2];
   wire isFile = (regIdx < `PFIA_IDX_WORK);
   // Index holes answer with an error
   wire holeIdx = (regIdx == `PFIA_IDX_HOLE_A) | (regIdx == `PFIA_IDX_HOLE_B)
                  | (regIdx == `PFIA_IDX_HOLE_C);
   wire unmapped = holeIdx | (regIdx > `PFIA_IDX_STACK2);
   wire viaIndirect = isFile & (regIdx == `PFIA_IDX_INDIRECT);
   wire [4:0] effAddr = viaIndirect ? ptr_r[4:0] : regIdx[4:0];
   wire effBank = viaIndirect & BANKED & ptr_r[5];
   wire selfPoint = viaIndirect & (ptr_r[4:0] == 5'h00);
   wire [5:0] effIdx = {1'b0, effAddr};
   wire isRam = (effIdx >= `PFIA_IDX_RAM_LO);
   wire [5:0] ramSel = ramIndex(effAddr, effBank);

   // ----------------------------------------
   // Read path
   // ----------------------------------------
   // unimplemented pointer bit 7 reads zero, bit 6 (and bit 5 when not banked) reads one
   wire [7:0] ptrRead = BANKED ? {2'b01, ptr_r} : {3'b011, ptr_r[4:0]};
   wire [7:0] fileByte = selfPoint ? 8'h00
                       : (effIdx == `PFIA_IDX_CNT_LOW) ? cnt_r[7:0]
                       : (effIdx == `PFIA_IDX_FLAGS) ? flags_r
                       : (effIdx == `PFIA_IDX_POINTER) ? ptrRead
                       : isRam ? ram_r[ramSel]
                       : 8'h00;
   wire [31:0] rdWord = unmapped ? 32'h0000_0000
                      : isFile ? {24'h00_0000, fileByte}
                      : (regIdx == `PFIA_IDX_WORK) ? {24'h00_0000, work_r}
                      : (regIdx == `PFIA_IDX_COUNTER) ? {22'h0, cnt_r}
                      : (regIdx == `PFIA_IDX_STACK1) ? {20'h0_0000, stk1_r}
                      : {20'h0_0000, stk2_r};

   // ----------------------------------------
   // Write path
   // ----------------------------------------
   wire wrFire = apbFire & pwrite & ~unmapped;
   wire fileWrite = wrFire & isFile & ~selfPoint;
   wire lowWrite = fileWrite & (effIdx == `PFIA_IDX_CNT_LOW);
   wire flagsWrite = fileWrite & (effIdx == `PFIA_IDX_FLAGS);
   wire ptrWrite = fileWrite & (effIdx == `PFIA_IDX_POINTER);
   wire ramWrite = fileWrite & isRam;
   // Status bits 4:3 are read-only
   wire [7:0] flagsNew = (flags_r & ~`PFIA_FLAGS_WMASK) | (pwdata[7:0] & `PFIA_FLAGS_WMASK);
   // Unbuilt pointer bits are not stored
   wire [5:0] ptrNew = BANKED ? pwdata[5:0] : {1'b0, pwdata[4:0]};

   // ----------------------------------------
   // Counter next value
   // ----------------------------------------
   // Bus write to the low byte wins over a step in the same cycle
   wire stepTaken = clkEn & instStep & ~lowWrite;
   wire [9:0] pageBase = {flags_r[`PFIA_FLAGS_PAGE_BIT], 9'h000} & CNT_MASK;
   // wrap from last location to zero
   wire [9:0] cntInc = (cnt_r + 10'h001) & CNT_MASK;
   wire [9:0] jumpCnt = (pageBase | {1'b0, instTarget}) & CNT_MASK;
   wire [9:0] callCnt = lowLoad(pageBase, instTarget[7:0]);
   wire [9:0] resCnt = lowLoad(pageBase, instLit);
   wire [9:0] retCnt = stk1_r[9:0] & CNT_MASK;

   // ----------------------------------------
   // Instruction decode
   // ----------------------------------------
   wire isCall = stepTaken & (instOp == pfia_pkg::PFIA_OP_CALL);
   wire isRet = stepTaken & (instOp == pfia_pkg::PFIA_OP_RETLIT);
   wire [11:0] pushWord = {2'b00, cntInc};

   always_comb begin
      cnt_nxt = cnt_r;
      if (lowWrite) begin
         // bus low-byte write clears bit 8
         cnt_nxt = lowLoad(pageBase, pwdata[7:0]);
      end else if (stepTaken) begin
         unique case (instOp)
            pfia_pkg::PFIA_OP_JUMP: cnt_nxt = jumpCnt;
            pfia_pkg::PFIA_OP_CALL: cnt_nxt = callCnt;
            pfia_pkg::PFIA_OP_RETLIT: cnt_nxt = retCnt;
            pfia_pkg::PFIA_OP_LOWRES: cnt_nxt = resCnt;
            default: cnt_nxt = cntInc;
         endcase
      end
   end

   // ----------------------------------------
   // Counter and stack
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         cnt_r <= CNT_MASK;
      end else if (clkEn) begin
         cnt_r <= cnt_nxt;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         stk2_r <= 12'h000;
      end else if (isCall) begin
         stk2_r <= stk1_r;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         stk1_r <= 12'h000;
      end else if (isCall) begin
         stk1_r <= pushWord;
      end else if (isRet) begin
         stk1_r <= stk2_r;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         work_r <= 8'h00;
      end else if (isRet) begin
         work_r <= instLit;
      end
   end

   // Step acknowledge, one cycle later
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         done_r <= 1'b0;
      end else if (clkEn) begin
         done_r <= stepTaken;
      end
   end

   // ----------------------------------------
   // Flags and pointer
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         flags_r <= `PFIA_FLAGS_RESET;
      end else if (clkEn && flagsWrite) begin
         flags_r <= flagsNew;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         ptr_r <= `PFIA_POINTER_RESET;
      end else if (clkEn && ptrWrite) begin
         ptr_r <= ptrNew;
      end
   end

   // ----------------------------------------
   // Data memory
   // ----------------------------------------
   // store lands at addressed or pointed location
   always_ff @(posedge ref_clk) begin
      if (clkEn && ramWrite) begin
         ram_r[ramSel] <= pwdata[7:0];
      end
   end

   // ----------------------------------------
   // Bus response
   // ----------------------------------------
   wire respond = apbAccess & ~pready_r;
   wire rdCapture = respond & ~pwrite;

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         pready_r <= 1'b0;
      end else if (clkEn) begin
         pready_r <= respond;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         pslverr_r <= 1'b0;
      end else if (clkEn) begin
         pslverr_r <= respond & unmapped;
      end
   end

   // Read data holds until the next read
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         prdata_r <= 32'h0000_0000;
      end else if (clkEn && rdCapture) begin
         prdata_r <= rdWord;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign cntOut = cnt_r;
   assign workReg = work_r;
   assign instDone = done_r;

endmodule : pfia_core

// ### pfia_core_checker.sv
`timescale 1ns/1ps
module pfia_core_checker #(
   parameter bit BANKED = 1'b1
) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic clkEn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic instStep,
   input wire pfia_pkg::pfia_op_t instOp,
   input wire logic [8:0] instTarget,
   input wire logic [7:0] instLit,
   input wire logic [9:0] cntOut,
   input wire logic [7:0] workReg,
   input wire logic instDone
);
   localparam logic [9:0] MASK = BANKED ? 10'h3ff : 10'h1ff;
   wire lowWr = psel && penable && pready && pwrite && (paddr[7:2] == 6'h02);
   wire stepOk = clkEn && instStep && !lowWr;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   property p_step;
      stepOk && instOp == pfia_pkg::PFIA_OP_STEP |=> cntOut == (($past(cntOut) + 10'h1) & MASK);
   endproperty
   a_step: assert property (p_step) else $error("counter did not advance");
   property p_jump;
      stepOk && instOp == pfia_pkg::PFIA_OP_JUMP |=> cntOut[8:0] == $past(instTarget);
   endproperty
   a_jump: assert property (p_jump) else $error("jump address wrong");
   property p_call;
      stepOk && instOp == pfia_pkg::PFIA_OP_CALL |=> !cntOut[8] && cntOut[7:0] == $past(instTarget[7:0]);
   endproperty
   a_call: assert property (p_call) else $error("call address wrong");
   property p_retlit;
      stepOk && instOp == pfia_pkg::PFIA_OP_RETLIT |=> workReg == $past(instLit);
   endproperty
   a_retlit: assert property (p_retlit) else $error("literal not loaded");
   property p_lowres;
      stepOk && instOp == pfia_pkg::PFIA_OP_LOWRES |=> !cntOut[8] && cntOut[7:0] == $past(instLit);
   endproperty
   a_lowres: assert property (p_lowres) else $error("computed branch wrong");
   property p_done;
      stepOk |=> instDone;
   endproperty
   a_done: assert property (p_done) else $error("step not acknowledged");
   property p_reset;
      $rose(rstn) |-> cntOut == MASK;
   endproperty
   a_reset: assert property (p_reset) else $error("reset vector wrong");
   property p_ready;
      clkEn && psel && penable && !pready |=> pready ##1 !pready;
   endproperty
   a_ready: assert property (p_ready) else $error("register access not answered");
endmodule : pfia_core_checker

bind pfia_core pfia_core_checker #(.BANKED(BANKED)) u_pfia_core_checker (
   .ref_clk(ref_clk), .rstn(rstn), .clkEn(clkEn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .instStep(instStep), .instOp(instOp), .instTarget(instTarget),
   .instLit(instLit), .cntOut(cntOut), .workReg(workReg), .instDone(instDone));

// ### pfia_core_tb.sv
`timescale 1ns/1ps
module pfia_core_tb;
   logic ref_clk = 1'b0, rstn = 1'b0, clkEn = 1'b1, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, pready, pslverr, instStep = 1'b0, instDone;
   logic [7:0] paddr = 8'h00, instLit = 8'h00, workReg;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [8:0] instTarget = 9'h000;
   logic [9:0] cntOut;
   logic [11:0] rd;
   logic err;
   pfia_pkg::pfia_op_t instOp = pfia_pkg::PFIA_OP_STEP;
   int badCount = 0, totalChecks = 0;
   always #50 ref_clk = ~ref_clk;
   pfia_core #(.BANKED(1'b1)) u_pfia_core (.ref_clk(ref_clk), .rstn(rstn), .clkEn(clkEn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .instStep(instStep),
      .instOp(instOp), .instTarget(instTarget), .instLit(instLit), .cntOut(cntOut),
      .workReg(workReg), .instDone(instDone));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      totalChecks++;
      if (got !== exp) begin
         badCount++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] wd);
      int n;
      n = 0;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h0, wd};
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1 && n < 20) begin
         @(posedge ref_clk);
         n++;
      end
      if (n >= 20) chk(12'hfff, 12'h000);
      rd = prdata[11:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Let the completing edge land before callers look
      @(posedge ref_clk);
   endtask : apb
   task automatic inst(input pfia_pkg::pfia_op_t op, input logic [8:0] t, input logic [7:0] l);
      @(posedge ref_clk);
      instStep <= 1'b1;
      instOp <= op;
      instTarget <= t;
      instLit <= l;
      @(posedge ref_clk);
      instStep <= 1'b0;
      @(posedge ref_clk);
   endtask : inst
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_flow;
      chk({2'b00, cntOut}, 12'h3ff);
      inst(pfia_pkg::PFIA_OP_STEP, 9'h000, 8'h00);
      chk({2'b00, cntOut}, 12'h000);
      apb(1'b0, 6'h03, 8'h00);
      chk(rd, 12'h018);
      apb(1'b1, 6'h03, 8'h20);
      inst(pfia_pkg::PFIA_OP_JUMP, 9'h123, 8'h00);
      chk({2'b00, cntOut}, 12'h323);
      apb(1'b1, 6'h02, 8'hab);
      chk({2'b00, cntOut}, 12'h2ab);
      apb(1'b0, 6'h02, 8'h00);
      chk(rd, 12'h0ab);
      inst(pfia_pkg::PFIA_OP_LOWRES, 9'h000, 8'h33);
      chk({2'b00, cntOut}, 12'h233);
      apb(1'b1, 6'h03, 8'h00);
   endtask : t_flow
   task automatic t_stack;
      inst(pfia_pkg::PFIA_OP_JUMP, 9'h010, 8'h00);
      inst(pfia_pkg::PFIA_OP_CALL, 9'h040, 8'h00);
      inst(pfia_pkg::PFIA_OP_CALL, 9'h080, 8'h00);
      inst(pfia_pkg::PFIA_OP_CALL, 9'h190, 8'h00);
      chk({2'b00, cntOut}, 12'h090);
      apb(1'b0, 6'h22, 8'h00);
      chk(rd, 12'h081);
      apb(1'b0, 6'h23, 8'h00);
      chk(rd, 12'h041);
      inst(pfia_pkg::PFIA_OP_RETLIT, 9'h000, 8'h5a);
      chk({2'b00, cntOut}, 12'h081);
      chk({4'h0, workReg}, 12'h05a);
      inst(pfia_pkg::PFIA_OP_RETLIT, 9'h000, 8'ha5);
      inst(pfia_pkg::PFIA_OP_RETLIT, 9'h000, 8'h00);
      chk({2'b00, cntOut}, 12'h041);
   endtask : t_stack
   task automatic t_indirect;
      apb(1'b1, 6'h07, 8'h10);
      apb(1'b1, 6'h08, 8'h0a);
      apb(1'b1, 6'h10, 8'h55);
      apb(1'b1, 6'h04, 8'h07);
      apb(1'b0, 6'h00, 8'h00);
      chk(rd, 12'h010);
      apb(1'b1, 6'h04, 8'h08);
      apb(1'b0, 6'h00, 8'h00);
      chk(rd, 12'h00a);
      apb(1'b1, 6'h04, 8'h00);
      apb(1'b1, 6'h00, 8'h99);
      apb(1'b0, 6'h00, 8'h00);
      chk(rd, 12'h000);
      apb(1'b0, 6'h04, 8'h00);
      chk(rd, 12'h040);
      apb(1'b1, 6'h04, 8'h30);
      apb(1'b1, 6'h00, 8'h77);
      apb(1'b0, 6'h04, 8'h00);
      chk(rd, 12'h070);
      apb(1'b1, 6'h04, 8'h10);
      apb(1'b0, 6'h00, 8'h00);
      chk(rd, 12'h055);
      apb(1'b1, 6'h04, 8'h30);
      apb(1'b0, 6'h00, 8'h00);
      chk(rd, 12'h077);
      apb(1'b0, 6'h10, 8'h00);
      chk(rd, 12'h055);
      apb(1'b0, 6'h01, 8'h00);
      chk({11'h0, err}, 12'h001);
   endtask : t_indirect
   task automatic t_freeze;
      clkEn <= 1'b0;
      inst(pfia_pkg::PFIA_OP_STEP, 9'h000, 8'h00);
      chk({2'b00, cntOut}, 12'h041);
      clkEn <= 1'b1;
      inst(pfia_pkg::PFIA_OP_STEP, 9'h000, 8'h00);
      chk({2'b00, cntOut}, 12'h042);
   endtask : t_freeze
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", totalChecks, badCount);
      if (badCount == 0 && totalChecks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : wrap_up
   initial begin
      repeat (16) @(posedge ref_clk);
      rstn <= 1'b1;
      t_flow();
      t_stack();
      t_freeze();
      t_indirect();
      wrap_up();
   end
   initial begin
      repeat (3000) @(posedge ref_clk);
      badCount++;
      wrap_up();
   end
endmodule : pfia_core_tb
